// ==== macc_pkg.sv ====
// shared constants, types and decode functions of the misaligned access checker
`default_nettype none
package macc_pkg;
  localparam int ADDR_W = 32;
  localparam int OFS_W = 8;
  localparam int CAUSE_W = 5;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_CAUSE = 8'h0c;
  localparam logic [7:0] OFS_BADADDR = 8'h10;
  localparam logic [7:0] OFS_FAULTPC = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_DATA_BIT = 0;
  localparam int ST_DEST_BIT = 1;
  localparam int CFG_OPT_BIT = 0;
  localparam int CFG_MMU_BIT = 1;
  localparam int CFG_MPU_BIT = 2;
  localparam int CFG_ACT_BIT = 3;

  // reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;

  // cause codes handed to the exception controller
  localparam logic [4:0] CAUSE_NONE = 5'h00;
  localparam logic [4:0] CAUSE_DATA = 5'h01;
  localparam logic [4:0] CAUSE_DEST = 5'h02;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_LOAD = 4'h1,
    OP_STORE = 4'h2,
    OP_BRANCH_ALWAYS = 4'h3,
    OP_CALL_REG = 4'h4,
    OP_JUMP_REG = 4'h5,
    OP_RETURN = 4'h6,
    OP_EXC_RETURN = 4'h7,
    OP_BRK_RETURN = 4'h8
  } macc_op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } macc_size_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RDWAIT = 2'b10
  } macc_bus_t;

  function automatic logic is_data_op(input macc_op_t op);
    return (op == OP_LOAD) || (op == OP_STORE);
  endfunction

  function automatic logic is_xfer_op(input macc_op_t op);
    return (op >= OP_BRANCH_ALWAYS) && (op <= OP_BRK_RETURN);
  endfunction
endpackage
`default_nettype wire

// ==== macc_chk_if.sv ====
// request and verdict signals between the checker top and its alignment decoder
`default_nettype none
interface macc_chk_if;
  import macc_pkg::*;
  logic active;
  macc_op_t op;
  macc_size_t size;
  logic [1:0] addr_lsb;
  logic data_mis;
  logic dest_mis;
  modport req (output active, op, size, addr_lsb, input data_mis, dest_mis);
  modport chk (input active, op, size, addr_lsb, output data_mis, dest_mis);
endinterface
`default_nettype wire

// ==== macc_align_dec.sv ====
// alignment decoder: flags misaligned data and control-transfer addresses
`default_nettype none
module macc_align_dec (
  macc_chk_if.chk cif // request in, verdict out
);
  import macc_pkg::*;

  always_comb begin
    cif.data_mis = 1'b0;
    cif.dest_mis = 1'b0;
    if (cif.active) begin
      if (is_data_op(cif.op)) begin
        case (cif.size)
          SZ_WORD: cif.data_mis = |cif.addr_lsb;
          SZ_HALF: cif.data_mis = cif.addr_lsb[0];
          SZ_BYTE: cif.data_mis = 1'b0;
          default: cif.data_mis = 1'b0;
        endcase
      end
      if (is_xfer_op(cif.op)) begin
        cif.dest_mis = |cif.addr_lsb;
      end
    end
  end
endmodule
`default_nettype wire

// ==== macc_top.sv ====
// misaligned access checker: pipeline-side check, fault record and ahb-lite registers
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`default_nettype none
module macc_top #(
  parameter bit MISALIGN_OPT = 1'b1, // misaligned check option built in
  parameter bit MMU_PRESENT = 1'b0, // memory management unit in the core
  parameter bit MPU_PRESENT = 1'b0 // memory protection unit in the core
) (
  input wire logic mclk_i, // core clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic ce_i, // clock enable, freezes all state when low
  // pipeline request
  input wire logic req_valid_i, // request present this cycle
  input wire macc_pkg::macc_op_t req_op_i, // operation kind
  input wire macc_pkg::macc_size_t req_size_i, // data access width
  input wire logic [macc_pkg::ADDR_W-1:0] req_addr_i, // data address or transfer target
  input wire logic [macc_pkg::ADDR_W-1:0] req_pc_i, // address of the instruction
  // verdict to pipeline and exception controller
  output logic mem_go_o, // load or store may access memory
  output logic xfer_go_o, // transfer may redirect fetch
  output logic wb_kill_o, // suppress destination register update
  output logic exc_take_o, // misaligned exception raised
  output logic [macc_pkg::CAUSE_W-1:0] exc_cause_o, // recorded cause code
  output logic [macc_pkg::ADDR_W-1:0] exc_badaddr_o, // bad-address register
  output logic [macc_pkg::ADDR_W-1:0] exc_pc_o, // faulting instruction address
  output logic irq_o, // level interrupt, unmasked status pending
  // ahb-lite slave
  input wire logic hsel_i, // slave select
  input wire logic [macc_pkg::ADDR_W-1:0] haddr_i, // address
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // write when high
  input wire logic [2:0] hsize_i, // transfer size
  input wire logic [31:0] hwdata_i, // write data
  input wire logic hready_i, // bus ready
  output logic hreadyout_o, // slave ready
  output logic [31:0] hrdata_o, // read data
  output logic hresp_o // response, always okay
);
  import macc_pkg::*;

  macc_chk_if cif ();

  logic ctrl_en;
  logic [1:0] status;
  logic [1:0] mask;
  logic check_active;
  logic data_op;
  logic xfer_op;
  logic data_fault;
  logic dest_fault;
  logic [1:0] st_set;
  logic [1:0] st_clr;
  logic [1:0] next_status;
  macc_bus_t bus_state;
  logic addr_phase;
  logic wr_pend;
  logic [OFS_W-1:0] wr_ofs;
  logic [OFS_W-1:0] rd_ofs;
  logic [31:0] rd_val;
  logic any_fault;
  logic rd_start;
  logic [1:0] next_mask;
  logic next_ctrl_en;

  // decodes the data phase of a whole-word write to one register
  function automatic logic reg_hit(input logic pend, input logic [OFS_W-1:0] at,
    input logic [OFS_W-1:0] ofs);
    return pend && (at == ofs);
  endfunction

  // a core with translation or protection always checks; the option bit is moot then
  assign check_active = MMU_PRESENT | MPU_PRESENT | (MISALIGN_OPT & ctrl_en);

  assign data_op = req_valid_i & is_data_op(req_op_i);
  assign xfer_op = req_valid_i & is_xfer_op(req_op_i);

  assign cif.active = check_active & req_valid_i;
  assign cif.op = req_op_i;
  assign cif.size = req_size_i;
  assign cif.addr_lsb = req_addr_i[1:0];

  macc_align_dec u_dec (
    .cif(cif.chk)
  );

  assign data_fault = data_op & cif.data_mis;
  assign dest_fault = xfer_op & cif.dest_mis;
  assign any_fault = data_fault | dest_fault;

  // verdict pulses, one cycle after the request
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      mem_go_o <= 1'b0;
    end else if (ce_i) begin
      mem_go_o <= data_op & ~cif.data_mis;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      xfer_go_o <= 1'b0;
    end else if (ce_i) begin
      xfer_go_o <= xfer_op & ~cif.dest_mis;
    end
  end

  // a faulting load must not write its destination register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wb_kill_o <= 1'b0;
    end else if (ce_i) begin
      wb_kill_o <= data_fault;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      exc_take_o <= 1'b0;
    end else if (ce_i) begin
      exc_take_o <= any_fault;
    end
  end

  // fault record: cause, bad address and the pc of the faulting instruction
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      exc_cause_o <= CAUSE_NONE;
    end else if (ce_i) begin
      if (data_fault) begin
        exc_cause_o <= CAUSE_DATA;
      end else if (dest_fault) begin
        exc_cause_o <= CAUSE_DEST;
      end
    end
  end

  // one request per cycle, so data and target faults never compete for the register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      exc_badaddr_o <= ADDR_RST;
    end else if (ce_i && any_fault) begin
      exc_badaddr_o <= req_addr_i;
    end
  end

  // the handler finds the faulting instruction here without walking the pipeline
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      exc_pc_o <= ADDR_RST;
    end else if (ce_i && any_fault) begin
      exc_pc_o <= req_pc_i;
    end
  end

  // ---- register bus ----
  assign addr_phase = hsel_i & hready_i & htrans_i[1];

  // a read opens only from idle; its own wait state holds off the next address phase
  assign rd_start = (bus_state == BUS_IDLE) & addr_phase & ~hwrite_i;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      bus_state <= BUS_IDLE;
    end else if (ce_i) begin
      case (bus_state)
        BUS_IDLE: begin
          if (rd_start) begin
            bus_state <= BUS_RDWAIT;
          end
        end
        BUS_RDWAIT: begin
          bus_state <= BUS_IDLE;
        end
        default: begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // reads take one wait state so a write just before is already visible
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      hreadyout_o <= 1'b1;
    end else if (ce_i) begin
      hreadyout_o <= ~rd_start;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rd_ofs <= '0;
    end else if (ce_i && rd_start) begin
      rd_ofs <= haddr_i[OFS_W-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (ce_i && bus_state == BUS_RDWAIT) begin
      hrdata_o <= rd_val;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      hresp_o <= HRESP_OKAY;
    end else if (ce_i) begin
      hresp_o <= HRESP_OKAY;
    end
  end

  // writes land at the end of their data phase; sub-word writes are dropped
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wr_pend <= 1'b0;
    end else if (ce_i) begin
      wr_pend <= addr_phase & hwrite_i & (hsize_i == HSIZE_WORD);
    end
  end

  // offset is latched every cycle; only wr_pend decides whether it matters
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wr_ofs <= '0;
    end else if (ce_i) begin
      wr_ofs <= haddr_i[OFS_W-1:0];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (rd_ofs)
      OFS_CTRL: rd_val[CTRL_EN_BIT] = ctrl_en;
      OFS_STATUS: rd_val[1:0] = status;
      OFS_MASK: rd_val[1:0] = mask;
      OFS_CAUSE: rd_val[CAUSE_W-1:0] = exc_cause_o;
      OFS_BADADDR: rd_val = exc_badaddr_o;
      OFS_FAULTPC: rd_val = exc_pc_o;
      OFS_CONFIG: begin
        rd_val[CFG_OPT_BIT] = MISALIGN_OPT;
        rd_val[CFG_MMU_BIT] = MMU_PRESENT;
        rd_val[CFG_MPU_BIT] = MPU_PRESENT;
        rd_val[CFG_ACT_BIT] = check_active;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // a mask write already counts in the edge that stores it; an enable write only acts from the next cycle on
  assign next_ctrl_en = reg_hit(wr_pend, wr_ofs, OFS_CTRL) ? hwdata_i[CTRL_EN_BIT] : ctrl_en;
  assign next_mask = reg_hit(wr_pend, wr_ofs, OFS_MASK) ? hwdata_i[1:0] : mask;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_en <= CTRL_EN_RST;
    end else if (ce_i) begin
      ctrl_en <= next_ctrl_en;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      mask <= MASK_RST;
    end else if (ce_i) begin
      mask <= next_mask;
    end
  end

  // sticky event bits, write one to clear; a new event beats the clear
  assign st_set = {dest_fault, data_fault};
  assign st_clr = reg_hit(wr_pend, wr_ofs, OFS_STATUS) ? hwdata_i[1:0] : 2'h0;
  assign next_status = (status & ~st_clr) | st_set;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      status <= STATUS_RST;
    end else if (ce_i) begin
      status <= next_status;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(next_status & next_mask);
    end
  end
endmodule
`default_nettype wire

// ==== macc_props.sv ====
// concurrent checks on the misaligned access checker top ports
`default_nettype none
module macc_props (
  input wire logic mclk_i, // clock
  input wire logic rstn_i, // reset, active low
  input wire logic ce_i, // clock enable
  input wire logic req_valid_i, // request
  input wire macc_pkg::macc_op_t req_op_i, // op
  input wire macc_pkg::macc_size_t req_size_i, // width
  input wire logic [31:0] req_addr_i, // address
  input wire logic [31:0] req_pc_i, // pc
  input wire logic mem_go_o, // memory go
  input wire logic xfer_go_o, // transfer go
  input wire logic wb_kill_o, // writeback kill
  input wire logic exc_take_o, // exception
  input wire logic [4:0] exc_cause_o, // cause
  input wire logic [31:0] exc_badaddr_o, // bad address
  input wire logic [31:0] exc_pc_o // fault pc
);
  timeunit 1ns;
  timeprecision 1ps;
  import macc_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_data; ce_i && req_valid_i && is_data_op(req_op_i); endsequence
  sequence s_xfer; ce_i && req_valid_i && is_xfer_op(req_op_i); endsequence
  property p_byte; s_data ##0 req_size_i == SZ_BYTE |=> mem_go_o && !exc_take_o; endproperty
  property p_word;
    s_data ##0 (req_size_i == SZ_WORD && req_addr_i[1:0] == 2'h0) |=> mem_go_o && !wb_kill_o;
  endproperty
  property p_half; s_data ##0 (req_size_i == SZ_HALF && req_addr_i[0]) |=> mem_go_o != wb_kill_o;
  endproperty
  property p_kill; wb_kill_o |-> exc_take_o && !mem_go_o && exc_cause_o == CAUSE_DATA; endproperty
  property p_dok; s_xfer ##0 req_addr_i[1:0] == 2'h0 |=> xfer_go_o && !exc_take_o; endproperty
  property p_dmis;
    s_xfer ##0 req_addr_i[1:0] != 2'h0 |=>
      (xfer_go_o ? !exc_take_o : exc_take_o && exc_cause_o == CAUSE_DEST);
  endproperty
  property p_bad;
    ce_i && req_valid_i ##1 exc_take_o |->
      exc_badaddr_o == $past(req_addr_i) && exc_pc_o == $past(req_pc_i);
  endproperty
  property p_idle; ce_i && !req_valid_i |=> !(mem_go_o || xfer_go_o || exc_take_o); endproperty
  a_byte: assert property (p_byte) else $error("byte access faulted");
  a_word: assert property (p_word) else $error("aligned word blocked");
  a_half: assert property (p_half) else $error("odd half verdict");
  a_kill: assert property (p_kill) else $error("kill without data fault");
  a_dok: assert property (p_dok) else $error("aligned target faulted");
  a_dmis: assert property (p_dmis) else $error("target fault cause wrong");
  a_bad: assert property (p_bad) else $error("fault record wrong");
  a_idle: assert property (p_idle) else $error("verdict without request");
endmodule
bind macc_top macc_props u_props (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
  .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_size_i(req_size_i),
  .req_addr_i(req_addr_i), .req_pc_i(req_pc_i), .mem_go_o(mem_go_o), .xfer_go_o(xfer_go_o),
  .wb_kill_o(wb_kill_o), .exc_take_o(exc_take_o), .exc_cause_o(exc_cause_o),
  .exc_badaddr_o(exc_badaddr_o), .exc_pc_o(exc_pc_o));
`default_nettype wire

// ==== macc_pipe_model.sv ====
// pipeline model issuing load, store and transfer requests
`default_nettype none
module macc_pipe_model (
  input wire logic mclk_i, // core clock
  output logic valid_o, // request present
  output var macc_pkg::macc_op_t op_o, // operation
  output var macc_pkg::macc_size_t size_o, // width
  output logic [31:0] addr_o, // data address or target
  output logic [31:0] pc_o // instruction address
);
  timeunit 1ns;
  timeprecision 1ps;
  import macc_pkg::*;
  initial begin
    valid_o = 1'b0;
    op_o = OP_NONE;
    size_o = SZ_BYTE;
    addr_o = 32'h0;
    pc_o = 32'h0;
  end
  task automatic issue(input macc_op_t op, input macc_size_t sz, input logic [31:0] a, p);
    valid_o <= 1'b1;
    op_o <= op;
    size_o <= sz;
    addr_o <= a;
    pc_o <= p;
    @(posedge mclk_i);
  endtask
  // released lines flip so a stale address is never mistaken for a live one
  task automatic idle();
    valid_o <= 1'b0;
    addr_o <= ~addr_o;
    pc_o <= ~pc_o;
    @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking testbench of the misaligned access checker
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import macc_pkg::*;
  logic mclk_i, rstn_i, hsel_i, hwrite_i, req_valid_i, mem_go_o, xfer_go_o, wb_kill_o;
  logic exc_take_o, irq_o, hreadyout_o, hresp_o, en, rd_ph, mmu_take;
  logic [1:0] htrans_i, st, msk;
  logic [2:0] hsize_i;
  logic [4:0] exc_cause_o, lc;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, exc_badaddr_o, exc_pc_o, req_addr_i, req_pc_i, lb;
  macc_op_t req_op_i;
  macc_size_t req_size_i;
  logic [31:0] qb[$];
  logic [9:0] qp[$];
  logic qm[$];
  int failures, n_compared, seed;
  logic [7:0] ofs[7] = '{OFS_CTRL, OFS_STATUS, OFS_MASK, OFS_CAUSE, OFS_BADADDR, 8'h1c, OFS_CONFIG};
  logic [31:0] rv[7] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h9};
  macc_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .req_valid_i(req_valid_i),
    .req_op_i(req_op_i), .req_size_i(req_size_i), .req_addr_i(req_addr_i), .req_pc_i(req_pc_i),
    .mem_go_o(mem_go_o), .xfer_go_o(xfer_go_o), .wb_kill_o(wb_kill_o), .exc_take_o(exc_take_o),
    .exc_cause_o(exc_cause_o), .exc_badaddr_o(exc_badaddr_o), .exc_pc_o(exc_pc_o), .irq_o(irq_o),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o));
  macc_pipe_model u_pipe (.mclk_i(mclk_i), .valid_o(req_valid_i), .op_o(req_op_i),
    .size_o(req_size_i), .addr_o(req_addr_i), .pc_o(req_pc_i));
  // build with a translation unit: checking must ignore both the option and the enable bit
  macc_top #(.MISALIGN_OPT(1'b0), .MMU_PRESENT(1'b1), .MPU_PRESENT(1'b0)) dut_mmu (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .req_valid_i(req_valid_i),
    .req_op_i(req_op_i), .req_size_i(req_size_i), .req_addr_i(req_addr_i), .req_pc_i(req_pc_i),
    .mem_go_o(), .xfer_go_o(), .wb_kill_o(), .exc_take_o(mmu_take), .exc_cause_o(),
    .exc_badaddr_o(), .exc_pc_o(), .irq_o(), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(), .hrdata_o(), .hresp_o());
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, exp);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do @(posedge mclk_i); while (!hreadyout_o);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    if (!w) qb.push_back(exp);
    do @(posedge mclk_i); while (!hreadyout_o);
  endtask
  task automatic req(input int o, s, input logic [31:0] a);
    logic mis, f;
    mis = (o < 3) ? (s == 2 ? a[1:0] != 2'h0 : s == 1 && a[0]) : a[1:0] != 2'h0;
    f = mis && en;
    if (f) begin
      st[o > 2] = 1'b1;
      lc = (o < 3) ? CAUSE_DATA : CAUSE_DEST;
      lb = a;
    end
    qp.push_back({o < 3 && !f, o > 2 && !f, o < 3 && f, f, f ? lc : 5'h0, |(st & msk)});
    qm.push_back(mis);
    u_pipe.issue(macc_op_t'(o), macc_size_t'(s), a, a ^ 32'h5a5a_0000);
  endtask
  always @(posedge mclk_i) begin
    if (rstn_i && (mem_go_o || xfer_go_o || exc_take_o)) begin
      chk(32'({mem_go_o, xfer_go_o, wb_kill_o, exc_take_o, exc_take_o ? exc_cause_o : 5'h0,
        irq_o}), 32'(qp.pop_front()));
      chk(32'(mmu_take), 32'(qm.pop_front()));
    end
    if (rd_ph && hreadyout_o) begin
      chk(hrdata_o, qb.pop_front());
      chk(32'(hresp_o), 32'(HRESP_OKAY));
      rd_ph = 1'b0;
    end
    if (hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o) rd_ph = 1'b1;
  end
  initial begin
    #50000;
    failures++;
    give_verdict();
  end
  initial begin
    seed = 32'h62e0;
    {failures, n_compared, rd_ph, st, msk, en, lc, lb} = '0;
    en = 1'b1;
    {rstn_i, hsel_i, haddr_i, htrans_i, hwrite_i, hwdata_i} = '0;
    hsize_i = HSIZE_WORD;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    foreach (ofs[i]) bus(1'b0, ofs[i], 32'h0, rv[i]);
    bus(1'b1, OFS_MASK, 32'h3, 32'h0);
    msk = 2'h3;
    for (int i = 0; i < 96; i++) begin
      if (i == 64) begin
        u_pipe.idle();
        repeat (2) @(posedge mclk_i);
        bus(1'b0, OFS_CAUSE, 32'h0, {27'h0, lc});
        bus(1'b0, OFS_BADADDR, 32'h0, lb);
        bus(1'b0, OFS_FAULTPC, 32'h0, lb ^ 32'h5a5a_0000);
        bus(1'b0, OFS_STATUS, 32'h0, {30'h0, st});
        bus(1'b1, OFS_STATUS, 32'h1, 32'h0);
        st[0] = 1'b0;
        bus(1'b0, OFS_STATUS, 32'h0, {30'h0, st});
        chk(32'(irq_o), 32'(|(st & msk)));
        bus(1'b1, OFS_CTRL, 32'h0, 32'h0);
        en = 1'b0;
        bus(1'b0, OFS_CONFIG, 32'h0, 32'h1);
      end
      req(1 + i % 8, $unsigned($random(seed)) % 3, $random(seed));
    end
    u_pipe.idle();
    repeat (3) @(posedge mclk_i);
    chk(32'(qp.size() + qb.size() + qm.size()), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
